/* timer16_byte_access_core_tb_top.sv */
`default_nettype none
`include "tmb_defs.svh"
module timer16_byte_access_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, ext_pin, cap_pin, cmp_pin, pwrite, psel, penable, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] v;
  logic [2:0] pins;
  logic bot, mx, top, e, p0;
  logic [4:0] irq;
  int fails = 0;
  int samples_checked = 0;
  int n;
  tmb_timer u_tmb_timer (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_pin(ext_pin), .capture_input_pin(cap_pin),
    .comparator_in(cmp_pin), .compare_output_pins(pins), .bottom_reached(bot),
    .max_reached(mx), .top_reached(top), .irq_pending(irq));
  tmb_cpu_model u_tmb_cpu_model (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    u_tmb_cpu_model.apb(1'b1, a, {24'h0, d}, q, e);
  endtask
  task automatic rd(input logic [11:0] a);
    u_tmb_cpu_model.apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic cnt(input logic [15:0] w);
    u_tmb_cpu_model.wr16(`TMB_OFF_CNT_LO, `TMB_OFF_CNT_HI, w);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    wr(`TMB_OFF_CTRL_B, 8'h10);
    rd(`TMB_OFF_CTRL_B);
    check(q, 32'h10);
    v[2:0] = pins;
    wr(`TMB_OFF_CTRL_C, 8'he0);
    rd(`TMB_OFF_CTRL_C);
    check(q, 32'h0);
    check(pins ^ v[2:0], 32'h7);
    // mode 9: compare a is top, its force must not reach the pin
    wr(`TMB_OFF_CTRL_A, 8'h01);
    p0 = pins[0];
    wr(`TMB_OFF_CTRL_C, 8'h80);
    rd(`TMB_OFF_CTRL_C);
    check(pins[0], p0);
    wr(`TMB_OFF_CTRL_B, 8'h00);
    wr(`TMB_OFF_CTRL_A, 8'h00);
    rd(`TMB_OFF_CTRL_A);
    check(q, 32'h0);
  endtask
  // shared holding byte across counter and compare; stopped counter holds
  task automatic t_hold;
    cnt(16'h1234);
    repeat (20) @(posedge clk_sys);
    u_tmb_cpu_model.rd16(`TMB_OFF_CNT_LO, `TMB_OFF_CNT_HI, v);
    check(v, 16'h1234);
    wr(`TMB_OFF_CNT_HI, 8'hab);
    wr(`TMB_OFF_CMPA_LO, 8'h55);
    rd(`TMB_OFF_CNT_LO);
    rd(`TMB_OFF_CMPA_HI);
    check(q, 32'hab);
    rd(`TMB_OFF_CMPA_LO);
    check(q, 32'h55);
    rd(`TMB_OFF_CNT_HI);
    check(q, 32'h12);
  endtask
  // one step per cycle at the fastest select
  // running read lands its low byte on 0x1ff, so a late holding copy shows 0x2ff
  task automatic t_run;
    cnt(16'h019a);
    wr(`TMB_OFF_CTRL_B, 8'h01);
    repeat (100) @(posedge clk_sys);
    u_tmb_cpu_model.rd16(`TMB_OFF_CNT_LO, `TMB_OFF_CNT_HI, v);
    check(v, 16'h01ff);
    wr(`TMB_OFF_CTRL_B, 8'h00);
    u_tmb_cpu_model.rd16(`TMB_OFF_CNT_LO, `TMB_OFF_CNT_HI, v);
    check(v, 16'h0207);
  endtask
  // external rising edges each count once
  task automatic t_ext;
    cnt(16'h0000);
    wr(`TMB_OFF_CTRL_B, 8'h07);
    repeat (5) begin
      ext_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_pin <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    wr(`TMB_OFF_CTRL_B, 8'h00);
    u_tmb_cpu_model.rd16(`TMB_OFF_CNT_LO, `TMB_OFF_CNT_HI, v);
    check(v, 16'h0005);
  endtask
  task automatic t_max;
    cnt(16'hfff0);
    wr(`TMB_OFF_CTRL_B, 8'h01);
    for (n = 0; n < 40 && mx !== 1'b1; n++) @(posedge clk_sys);
    check(mx, 1'b1);
    for (n = 0; n < 4 && bot !== 1'b1; n++) @(posedge clk_sys);
    check(bot, 1'b1);
    wr(`TMB_OFF_CTRL_B, 8'h00);
  endtask
  // fixed tops by low mode bits, each must wrap there
  task automatic t_top;
    logic [15:0] tops [3] = '{16'h00ff, 16'h01ff, 16'h03ff};
    for (int m = 1; m < 4; m++) begin
      wr(`TMB_OFF_CTRL_A, 8'(m));
      cnt(tops[m - 1] - 16'd3);
      wr(`TMB_OFF_CTRL_B, 8'h01);
      for (n = 0; n < 40 && top !== 1'b1; n++) @(posedge clk_sys);
      check(top, 1'b1);
      wr(`TMB_OFF_CTRL_B, 8'h00);
      u_tmb_cpu_model.rd16(`TMB_OFF_CNT_LO, `TMB_OFF_CNT_HI, v);
      check(v < 16'd16, 1'b1);
    end
    wr(`TMB_OFF_CTRL_A, 8'h00);
  endtask
  task automatic t_cmp;
    wr(`TMB_OFF_FLAG, 8'h1f);
    wr(`TMB_OFF_MASK, 8'h02);
    u_tmb_cpu_model.wr16(`TMB_OFF_CMPA_LO, `TMB_OFF_CMPA_HI, 16'h0040);
    cnt(16'h0030);
    p0 = pins[0];
    wr(`TMB_OFF_CTRL_B, 8'h01);
    for (n = 0; n < 40 && irq[1] !== 1'b1; n++) @(posedge clk_sys);
    check(irq[1], 1'b1);
    check(pins[0], !p0);
    check(irq[2], 1'b0);
    wr(`TMB_OFF_CTRL_B, 8'h00);
    wr(`TMB_OFF_MASK, 8'h00);
    rd(`TMB_OFF_FLAG);
    check(q[1], 1'b1);
    wr(`TMB_OFF_FLAG, 8'h02);
    rd(`TMB_OFF_FLAG);
    check(q[1], 1'b0);
  endtask
  // capture of a stopped counter on a filtered rising pin edge
  task automatic t_cap;
    wr(`TMB_OFF_CTRL_B, 8'hc0);
    cnt(16'h0777);
    cap_pin <= 1'b1;
    repeat (12) @(posedge clk_sys);
    u_tmb_cpu_model.rd16(`TMB_OFF_CAP_LO, `TMB_OFF_CAP_HI, v);
    check(v, 16'h0777);
    rd(`TMB_OFF_FLAG);
    check(q[4], 1'b1);
  endtask
  task automatic t_bad;
    wr(12'h03c, 8'h5a);
    check(e, 1'b1);
    rd(12'h03c);
    check(e, 1'b1);
    check(q, 32'h0);
  endtask
  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    results();
  end
  initial begin
    rst = 1'b1;
    ext_pin = 1'b0;
    cap_pin = 1'b0;
    cmp_pin = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_hold();
    t_run();
    t_max();
    t_top();
    t_cmp();
    t_cap();
    t_ext();
    t_bad();
    results();
  end
endmodule
`default_nettype wire

/* tmb_cpu_model.sv */
`default_nettype none
module tmb_cpu_model (
  input wire logic clk_sys,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // one transfer; released lines show inverted junk, not stale data
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // wide write, upper byte staged first; calls never interleave
  task automatic wr16(input logic [11:0] lo, input logic [11:0] hi, input logic [15:0] v);
    logic [31:0] q;
    logic e;
    apb(1'b1, hi, {24'h0, v[15:8]}, q, e);
    apb(1'b1, lo, {24'h0, v[7:0]}, q, e);
  endtask
  // wide read, low byte first so the holding byte is fresh
  task automatic rd16(input logic [11:0] lo, input logic [11:0] hi, output logic [15:0] v);
    logic [31:0] q;
    logic e;
    apb(1'b0, lo, 32'h0, q, e);
    v[7:0] = q[7:0];
    apb(1'b0, hi, 32'h0, q, e);
    v[15:8] = q[7:0];
  endtask
endmodule
`default_nettype wire

/* tmb_defs.svh */
`ifndef TMB_DEFS_SVH
`define TMB_DEFS_SVH
// ----------------------------------------
// byte register offsets (apb byte addresses)
// ----------------------------------------
`define TMB_OFF_CTRL_A 12'h000
`define TMB_OFF_CTRL_B 12'h004
`define TMB_OFF_CTRL_C 12'h008
`define TMB_OFF_CNT_LO 12'h00c
`define TMB_OFF_CNT_HI 12'h010
`define TMB_OFF_CMPA_LO 12'h014
`define TMB_OFF_CMPA_HI 12'h018
`define TMB_OFF_CMPB_LO 12'h01c
`define TMB_OFF_CMPB_HI 12'h020
`define TMB_OFF_CMPC_LO 12'h024
`define TMB_OFF_CMPC_HI 12'h028
`define TMB_OFF_CAP_LO 12'h02c
`define TMB_OFF_CAP_HI 12'h030
`define TMB_OFF_FLAG 12'h034
`define TMB_OFF_MASK 12'h038
// ----------------------------------------
// field positions
// ----------------------------------------
`define TMB_WGM_LO_MSB 1
`define TMB_WGM_LO_LSB 0
`define TMB_WGM_MSB_BIT 4
`define TMB_WGM_B2_BIT 3
`define TMB_CS_MSB 2
`define TMB_CS_LSB 0
`define TMB_CAP_EDGE_BIT 6
`define TMB_CAP_FILT_BIT 7
`define TMB_CAP_SRC_BIT 5
`define TMB_FOC_A_BIT 7
`define TMB_FOC_B_BIT 6
`define TMB_FOC_C_BIT 5
`define TMB_FLG_OVF 0
`define TMB_FLG_CMPA 1
`define TMB_FLG_CMPB 2
`define TMB_FLG_CMPC 3
`define TMB_FLG_CAP 4
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define TMB_RST_BYTE 8'h00
`define TMB_RST_WORD 16'h0000
`define TMB_BOTTOM 16'h0000
`define TMB_MAX 16'hffff
`define TMB_TOP_8 16'h00ff
`define TMB_TOP_9 16'h01ff
`define TMB_TOP_10 16'h03ff
`define TMB_FILT_LEN 4
`endif

/* tmb_edge_sync.sv */
`default_nettype none
`include "tmb_defs.svh"
// two-flop synchroniser, optional noise filter and edge detector for one pin
module tmb_edge_sync (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin_in,
  input wire logic filter_en,
  output logic rise,
  output logic fall
);
  logic sync_a;
  logic sync_b;
  logic [`TMB_FILT_LEN-1:0] hist;
  logic filt;
  logic prev;
  logic level;
  // ----------------------------------------
  // synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
    end
  end
  // filter accepts a level only after it held for several samples
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hist <= '0;
      filt <= 1'b0;
    end else begin
      hist <= {hist[`TMB_FILT_LEN-2:0], sync_b};
      if (&hist) begin
        filt <= 1'b1;
      end else if (~|hist) begin
        filt <= 1'b0;
      end
    end
  end
  assign level = filter_en ? filt : sync_b;
  // edge detector, compare against previous chosen level
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end
  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule
`default_nettype wire

/* tmb_monitor.sv */
`default_nettype none
`include "tmb_defs.svh"
module tmb_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bottom_reached,
  input wire logic max_reached,
  input wire logic [4:0] irq_pending
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  logic bad_addr;
  // misaligned or past the last register
  assign bad_addr = (paddr > `TMB_OFF_MASK) || (paddr[1:0] != 2'h0);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_answer)
    else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_err_unmapped: assert property (s_setup ##0 bad_addr |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_good_no_err: assert property (s_setup ##0 !bad_addr |=> !pslverr)
    else $error("mapped access refused");
  a_ctrl_c_reads_zero: assert property (
    s_setup ##0 (!pwrite && paddr == `TMB_OFF_CTRL_C) |=> prdata == 32'h0)
    else $error("force strobes read back");
  a_mask_gates_irq: assert property (
    s_answer ##0 (pwrite && paddr == `TMB_OFF_MASK && pwdata[4:0] == 5'h00)
    |=> ##1 irq_pending == 5'h00)
    else $error("masked request still pending");
  a_bottom_max_apart: assert property (!(bottom_reached && max_reached))
    else $error("bottom and max together");
  a_irq_masked: assert property (
    s_answer ##0 (pwrite && paddr == `TMB_OFF_MASK)
    |=> ##1 (irq_pending & ~$past(pwdata[4:0], 2)) == 5'h00)
    else $error("request pending past its mask");
endmodule
bind tmb_timer tmb_monitor u_tmb_monitor (.clk_sys(clk_sys), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .bottom_reached(bottom_reached),
  .max_reached(max_reached), .irq_pending(irq_pending));
`default_nettype wire

/* tmb_pkg.sv */
`default_nettype none
package tmb_pkg;
  typedef enum logic [2:0] {
    tmb_cs_stop = 3'h0,
    tmb_cs_div1 = 3'h1,
    tmb_cs_div8 = 3'h2,
    tmb_cs_div64 = 3'h3,
    tmb_cs_div256 = 3'h4,
    tmb_cs_div1024 = 3'h5,
    tmb_cs_ext_fall = 3'h6,
    tmb_cs_ext_rise = 3'h7
  } tmb_clk_sel_type;
  typedef enum logic [1:0] {
    tmb_top_fixed_max = 2'h0,
    tmb_top_fixed = 2'h1,
    tmb_top_cmpa = 2'h2,
    tmb_top_capture = 2'h3
  } tmb_top_src_type;
endpackage
`default_nettype wire

/* tmb_timer.sv */
`default_nettype none
`include "tmb_defs.svh"
//
// Contract
// RULE1 - counter, compares and capture are 16 bits, reached as two byte accesses
// RULE2 - one shared 8-bit high-byte holding register for all wide registers
// RULE3 - low-byte write loads holding byte and written byte together
// RULE4 - low-byte read copies upper byte into holding register same cycle
// RULE5 - compare reads return both bytes directly, holding register untouched
// RULE6 - software writes high byte first, reads low byte first
// RULE7 - software blocks interrupts around two-byte accesses
// RULE8 - three 8-bit control registers freely readable and writable; control c always reads back zero here
// RULE9 - every request shows as flag, each gated by own mask bit
// RULE10 - clock select picks prescaled or external edge; none keeps counter idle
// RULE11 - buffered compares matched continuously, setting flag and driving output
// RULE12 - bottom signalled when counter becomes zero
// RULE13 - max signalled when counter becomes all ones
// RULE14 - top is fixed 0x00ff/0x01ff/0x03ff, compare a, or capture by mode
// RULE15 - compare a as top gives no pwm output on a and is buffered; not in mode 4, where pin a toggles and it is unbuffered
// RULE16 - pin or comparator edge latches counter into capture, optional filter
// RULE17 - control c holds force strobes, control b holds mode msb
// RULE18 - clock select zero stops counter, still accessible
// RULE19 - capture flag set in same cycle as capture
// RULE20 - counter advances at most once per cycle on tick enable
module tmb_timer
  import tmb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_pin,
  input wire logic capture_input_pin,
  input wire logic comparator_in,
  output logic [2:0] compare_output_pins,
  output logic bottom_reached,
  output logic max_reached,
  output logic top_reached,
  output logic [4:0] irq_pending
);
  logic [7:0] timer_control_a;
  logic [7:0] timer_control_b;
  logic [7:0] timer_control_c;
  logic [7:0] hold_hi;
  logic [15:0] count_value;
  logic [15:0] compare_value [3];
  logic [15:0] compare_buf [3];
  logic [15:0] capture_value;
  logic [4:0] timer_flag_reg;
  logic [4:0] timer_mask_reg;
  logic [9:0] prescale;
  logic tick_p1, tick_p8, tick_p64, tick_p256, tick_p1024;
  logic timer_tick_enable;
  logic ext_rise, ext_fall, cap_rise, cap_fall;
  logic capture_event;
  logic [3:0] waveform_mode_field;
  logic [15:0] top_value;
  logic [2:0] match;
  logic top_hit;
  logic acc, wr, rd;
  logic [7:0] wbyte;
  logic cap_pin_sel;
  tmb_clk_sel_type clock_select_field;
  tmb_top_src_type top_src;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign wbyte = pwdata[7:0];
  assign clock_select_field = tmb_clk_sel_type'(timer_control_b[`TMB_CS_MSB:`TMB_CS_LSB]);
  // see RULE17
  assign waveform_mode_field = {timer_control_b[`TMB_WGM_MSB_BIT],
    timer_control_b[`TMB_WGM_B2_BIT], timer_control_a[`TMB_WGM_LO_MSB:`TMB_WGM_LO_LSB]};
  assign cap_pin_sel = timer_control_b[`TMB_CAP_SRC_BIT] ? comparator_in : capture_input_pin;
  // ----------------------------------------
  // pin edge detection
  // ----------------------------------------
  tmb_edge_sync u_ext (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(external_count_pin),
    .filter_en(1'b0),
    .rise(ext_rise),
    .fall(ext_fall)
  );
  tmb_edge_sync u_cap (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(cap_pin_sel),
    .filter_en(timer_control_b[`TMB_CAP_FILT_BIT]),
    .rise(cap_rise),
    .fall(cap_fall)
  );
  // switching capture source may itself look like an edge, as on the real part
  assign capture_event = timer_control_b[`TMB_CAP_EDGE_BIT] ? cap_rise : cap_fall; // see RULE16
  // ----------------------------------------
  // prescaler and clock select
  // ----------------------------------------
  // free running, so first prescaled tick after enable lands anywhere in a period
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 10'h001;
    end
  end
  assign tick_p1 = 1'b1;
  assign tick_p8 = (prescale[2:0] == 3'h7);
  assign tick_p64 = (prescale[5:0] == 6'h3f);
  assign tick_p256 = (prescale[7:0] == 8'hff);
  assign tick_p1024 = (prescale == 10'h3ff);
  // source select; stop code leaves counter idle
  always_comb begin
    unique case (clock_select_field)
      tmb_cs_stop: timer_tick_enable = 1'b0; // see RULE18
      tmb_cs_div1: timer_tick_enable = tick_p1; // see RULE10
      tmb_cs_div8: timer_tick_enable = tick_p8;
      tmb_cs_div64: timer_tick_enable = tick_p64;
      tmb_cs_div256: timer_tick_enable = tick_p256;
      tmb_cs_div1024: timer_tick_enable = tick_p1024;
      tmb_cs_ext_fall: timer_tick_enable = ext_fall;
      tmb_cs_ext_rise: timer_tick_enable = ext_rise;
    endcase
  end
  // ----------------------------------------
  // top selection
  // ----------------------------------------
  function automatic tmb_top_src_type top_kind(input logic [3:0] mode);
    case (mode)
      4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7: top_kind = tmb_top_fixed;
      4'h4, 4'h9, 4'hb, 4'hf: top_kind = tmb_top_cmpa;
      4'h8, 4'ha, 4'he, 4'hc: top_kind = tmb_top_capture;
      default: top_kind = tmb_top_fixed_max;
    endcase
  endfunction
  // pwm-style modes where compare a is top
  function automatic logic a_is_pwm_top(input logic [3:0] mode);
    a_is_pwm_top = (mode == 4'h9) || (mode == 4'hb) || (mode == 4'hf);
  endfunction
  assign top_src = top_kind(waveform_mode_field);
  always_comb begin
    unique case (top_src)
      tmb_top_fixed_max: top_value = `TMB_MAX;
      tmb_top_fixed: begin
        unique case (waveform_mode_field[1:0])
          2'h1: top_value = `TMB_TOP_8; // see RULE14
          2'h2: top_value = `TMB_TOP_9;
          default: top_value = `TMB_TOP_10;
        endcase
      end
      tmb_top_cmpa: top_value = compare_value[0];
      tmb_top_capture: top_value = capture_value;
    endcase
  end
  assign top_hit = (count_value == top_value);
  // ----------------------------------------
  // counter; a cpu write wins over counting
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_value <= `TMB_RST_WORD;
    end else if (wr && paddr == `TMB_OFF_CNT_LO) begin
      count_value <= {hold_hi, wbyte}; // see RULE3
    end else if (timer_tick_enable) begin
      count_value <= top_hit ? `TMB_BOTTOM : count_value + 16'h0001; // see RULE20
    end
  end
  // ----------------------------------------
  // shared high-byte holding register
  // ----------------------------------------
  // low-read copy at setup, the cycle prdata samples the low byte, so no carry splits them
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_hi <= `TMB_RST_BYTE;
    end else if (wr && (paddr == `TMB_OFF_CNT_HI || paddr == `TMB_OFF_CMPA_HI ||
        paddr == `TMB_OFF_CMPB_HI || paddr == `TMB_OFF_CMPC_HI ||
        paddr == `TMB_OFF_CAP_HI)) begin
      hold_hi <= wbyte; // see RULE2
    end else if (psel && !penable && !pwrite && paddr == `TMB_OFF_CNT_LO) begin
      hold_hi <= count_value[15:8]; // see RULE4
    end else if (psel && !penable && !pwrite && paddr == `TMB_OFF_CAP_LO) begin
      hold_hi <= capture_value[15:8];
    end
  end
  // ----------------------------------------
  // compare registers, buffered; updated at top only when compare a is pwm top (modes 9, b, f)
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cmp
      localparam logic [11:0] OFF_LO = `TMB_OFF_CMPA_LO + 12'(8 * gi);
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          compare_buf[gi] <= `TMB_RST_WORD;
        end else if (wr && paddr == OFF_LO) begin
          compare_buf[gi] <= {hold_hi, wbyte}; // see RULE3
        end
      end
      // active value follows buffer at top in pwm modes, else at once
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          compare_value[gi] <= `TMB_RST_WORD;
        end else if (!a_is_pwm_top(waveform_mode_field) || (timer_tick_enable && top_hit)) begin
          compare_value[gi] <= compare_buf[gi]; // see RULE15
        end
      end
      assign match[gi] = (count_value == compare_value[gi]); // see RULE11
    end
  endgenerate
  // ----------------------------------------
  // capture register; writable only when it is top
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      capture_value <= `TMB_RST_WORD;
    end else if (top_src == tmb_top_capture) begin
      if (wr && paddr == `TMB_OFF_CAP_LO) begin
        capture_value <= {hold_hi, wbyte};
      end
    end else if (capture_event) begin
      capture_value <= count_value; // see RULE16
    end
  end
  // ----------------------------------------
  // control registers, plain byte access
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timer_control_a <= `TMB_RST_BYTE;
      timer_control_b <= `TMB_RST_BYTE;
      timer_control_c <= `TMB_RST_BYTE;
    end else begin
      timer_control_c <= `TMB_RST_BYTE; // force strobes last one cycle
      if (wr && paddr == `TMB_OFF_CTRL_A) timer_control_a <= wbyte; // see RULE8
      if (wr && paddr == `TMB_OFF_CTRL_B) timer_control_b <= wbyte;
      if (wr && paddr == `TMB_OFF_CTRL_C) timer_control_c <= wbyte; // see RULE17
    end
  end
  // ----------------------------------------
  // flags and mask; set wins over write-one clear
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timer_flag_reg <= 5'h00;
    end else begin
      for (int i = 0; i < 5; i++) begin
        logic set;
        set = 1'b0;
        unique case (i)
          `TMB_FLG_OVF: set = timer_tick_enable && count_value == `TMB_MAX;
          `TMB_FLG_CAP: set = capture_event && top_src != tmb_top_capture; // see RULE19
          default: set = timer_tick_enable && match[i - 1]; // see RULE11
        endcase
        if (set) begin
          timer_flag_reg[i] <= 1'b1; // see RULE9
        end else if (wr && paddr == `TMB_OFF_FLAG && pwdata[i]) begin
          timer_flag_reg[i] <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timer_mask_reg <= 5'h00;
    end else if (wr && paddr == `TMB_OFF_MASK) begin
      timer_mask_reg <= pwdata[4:0];
    end
  end
  // ----------------------------------------
  // status and compare outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bottom_reached <= 1'b0;
      max_reached <= 1'b0;
      top_reached <= 1'b0;
      irq_pending <= 5'h00;
    end else begin
      bottom_reached <= (count_value == `TMB_BOTTOM); // see RULE12
      max_reached <= (count_value == `TMB_MAX); // see RULE13
      top_reached <= top_hit; // see RULE14
      irq_pending <= timer_flag_reg & timer_mask_reg; // see RULE9
    end
  end
  // toggle on match or force; channel a silent when it is pwm top
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      compare_output_pins <= 3'h0;
    end else begin
      if (!a_is_pwm_top(waveform_mode_field) &&
          ((timer_tick_enable && match[0]) || timer_control_c[`TMB_FOC_A_BIT])) begin
        compare_output_pins[0] <= ~compare_output_pins[0]; // see RULE15
      end
      if ((timer_tick_enable && match[1]) || timer_control_c[`TMB_FOC_B_BIT]) begin
        compare_output_pins[1] <= ~compare_output_pins[1];
      end
      if ((timer_tick_enable && match[2]) || timer_control_c[`TMB_FOC_C_BIT]) begin
        compare_output_pins[2] <= ~compare_output_pins[2];
      end
    end
  end
  // ----------------------------------------
  // apb slave: zero wait, unmapped reads zero with error
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel & ~penable & ~pwrite) begin
        unique case (paddr)
          `TMB_OFF_CTRL_A: prdata <= {24'h000000, timer_control_a};
          `TMB_OFF_CTRL_B: prdata <= {24'h000000, timer_control_b};
          `TMB_OFF_CTRL_C: prdata <= 32'h00000000;
          `TMB_OFF_CNT_LO: prdata <= {24'h000000, count_value[7:0]}; // see RULE1
          `TMB_OFF_CNT_HI, `TMB_OFF_CAP_HI: prdata <= {24'h000000, hold_hi}; // see RULE4
          `TMB_OFF_CMPA_LO: prdata <= {24'h000000, compare_buf[0][7:0]}; // see RULE5
          `TMB_OFF_CMPA_HI: prdata <= {24'h000000, compare_buf[0][15:8]};
          `TMB_OFF_CMPB_LO: prdata <= {24'h000000, compare_buf[1][7:0]};
          `TMB_OFF_CMPB_HI: prdata <= {24'h000000, compare_buf[1][15:8]};
          `TMB_OFF_CMPC_LO: prdata <= {24'h000000, compare_buf[2][7:0]};
          `TMB_OFF_CMPC_HI: prdata <= {24'h000000, compare_buf[2][15:8]};
          `TMB_OFF_CAP_LO: prdata <= {24'h000000, capture_value[7:0]};
          `TMB_OFF_FLAG: prdata <= {27'h0000000, timer_flag_reg};
          `TMB_OFF_MASK: prdata <= {27'h0000000, timer_mask_reg};
          default: pslverr <= 1'b1;
        endcase
      end else if (psel & ~penable) begin
        pslverr <= !(paddr <= `TMB_OFF_MASK && paddr[1:0] == 2'h0);
      end
    end
  end
endmodule
`default_nettype wire
